/* fdpd_decode.sv */
// Floppy command parameter decoder with APB registers and drive sequencing.
`timescale 1ns/1ps
`include "fdpd_params.svh"
module fdpd_decode
    import fdpd_pkg::*;
#(
    parameter int TICK_CYCLES = `FDPD_MS_NS / `FDPD_CLK_NS
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive and sequencer pins, asynchronous to clk.
    input  wire logic        seek_done_pin,
    input  wire logic        sector_done_pin,
    input  wire logic        id_valid_pin,
    input  wire logic        id_head_pin,
    // Drive control outputs.
    output logic             seek_req,
    output logic [7:0]       seek_cyl,
    output logic             head_load,
    output logic             head_side,
    output logic             sector_req,
    output logic [7:0]       sector_num,
    output logic             mfm_mode,
    output logic             fifo_on,
    output logic [7:0]       gap2_len,
    output logic [7:0]       gap3_len,
    output logic             xfer_done
);
    fdpd_cfg_t   cfg;
    fdpd_cmd_t   cmd;
    fdpd_state_t state;
    fdpd_state_t next_state;
    logic [7:0]  gap3_length;
    logic [7:0]  perp_gap;
    logic [7:0]  head_load_delay;
    logic [7:0]  head_unload_delay;
    logic        id_mismatch;
    logic [16:0] tick_div;
    logic [7:0]  ms_cnt;
    wire  [3:0]  sync2;
    wire  [3:0]  sync3;

    // All checks run on the one clock and rest while reset is low.
    default clocking chk_clk @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Two-flop synchronisers; a third stage only feeds the edge detectors.
    // Each bit keeps its own flops, so no vector has two writing processes.
    wire  [3:0]  pin_async = {id_head_pin, id_valid_pin, sector_done_pin,
                              seek_done_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            logic meta;
            logic stage2;
            logic stage3;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta   <= 1'b0;
                    stage2 <= 1'b0;
                    stage3 <= 1'b0;
                end else begin
                    meta   <= pin_async[gi];
                    stage2 <= meta;
                    stage3 <= stage2;
                end
            end
            assign sync2[gi] = stage2;
            assign sync3[gi] = stage3;
        end
    endgenerate

    // Bus decode and pin events.
    wire        acc       = psel & penable & pready;
    wire        wr        = acc & pwrite;
    wire        hit_cfg   = paddr == `FDPD_OFF_CFG;
    wire        hit_cmd   = paddr == `FDPD_OFF_CMD;
    wire        hit_gap   = paddr == `FDPD_OFF_GAP;
    wire        hit_time  = paddr == `FDPD_OFF_TIME;
    wire        hit_srst  = paddr == `FDPD_OFF_SRST;
    wire        hit_stat  = paddr == `FDPD_OFF_STAT;
    wire        mapped    = hit_cfg | hit_cmd | hit_gap | hit_time
                          | hit_srst | hit_stat;
    wire        soft_rst  = wr & hit_srst
                          & (pwdata[`FDPD_SRST_RATE_BIT]
                          | pwdata[`FDPD_SRST_DOR_BIT]);
    wire        go_ok     = state == ST_IDLE || state == ST_HOLD;
    wire        go        = wr & hit_cmd & pwdata[`FDPD_CMD_GO_BIT] & go_ok;
    wire        seek_ok   = sync2[0];
    wire        sect_evt  = sync2[1] & ~sync3[1];
    wire        id_evt    = sync2[2] & ~sync3[2];
    wire        id_head   = sync2[3];
    wire        tick      = tick_div == 17'(TICK_CYCLES - 1);
    wire        last_sect = sector_num == cmd.final_sector_number;
    wire        wrap_head = cmd.multi_track_select & ~head_side;
    wire        load_ok   = ms_cnt >= head_load_delay;
    wire        unload_ok = ms_cnt >= head_unload_delay;
    wire [31:0] stat_word = {13'h0000, xfer_done, id_mismatch, head_side,
                             sector_num, 3'h0, state};
    wire [31:0] rd_word   =
        hit_cfg  ? {16'h0000, cfg.precomp_start_track, cfg.fifo_threshold,
                    1'b0, cfg.lock, cfg.implied_seek_enable,
                    cfg.fifo_enable_n} :
        hit_cmd  ? {4'h0, cmd} :
        hit_gap  ? {16'h0000, perp_gap, gap3_length} :
        hit_time ? {16'h0000, head_unload_delay, head_load_delay} :
        hit_stat ? stat_word : 32'h0000_0000;

    // One wait state on every access; unmapped addresses answer an error.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= psel & penable & ~pready & ~pwrite ? rd_word
                                                           : 32'h0000_0000;
        end
    end

    // Configure parameters; lock shields three of them from soft reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg.fifo_enable_n       <= `FDPD_RST_FIFO_N;
            cfg.fifo_threshold      <= `FDPD_RST_FIFO_THR;
            cfg.precomp_start_track <= `FDPD_RST_PRECOMP_START_TRACK;
            cfg.implied_seek_enable <= 1'b0;
            cfg.lock                <= 1'b0;
        end else if (soft_rst && !cfg.lock) begin
            cfg.fifo_enable_n       <= `FDPD_RST_FIFO_N;
            cfg.fifo_threshold      <= `FDPD_RST_FIFO_THR;
            cfg.precomp_start_track <= `FDPD_RST_PRECOMP_START_TRACK;
        end else if (wr && hit_cfg) begin
            cfg.fifo_enable_n       <= pwdata[0];
            cfg.implied_seek_enable <= pwdata[1];
            cfg.lock                <= pwdata[2];
            cfg.fifo_threshold      <= pwdata[7:4];
            cfg.precomp_start_track <= pwdata[15:8];
        end
    end

    // Command, gap and delay parameters; the go bit rides on the command.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd               <= '0;
            gap3_length       <= 8'h00;
            perp_gap          <= 8'h00;
            head_load_delay   <= 8'h00;
            head_unload_delay <= 8'h00;
        end else begin
            if (wr && hit_cmd && go_ok) begin
                cmd <= pwdata[27:0];
            end
            if (wr && hit_gap) begin
                gap3_length <= pwdata[7:0];
                perp_gap    <= pwdata[15:8];
            end
            if (wr && hit_time) begin
                head_load_delay   <= pwdata[7:0];
                head_unload_delay <= pwdata[15:8];
            end
        end
    end

    // Millisecond tick and delay counter, restarted on each state change.
    always_ff @(posedge clk) begin
        if (!rst_n || next_state != state) begin
            tick_div <= 17'h00000;
            ms_cnt   <= 8'h00;
        end else begin
            tick_div <= tick ? 17'h00000 : tick_div + 17'h00001;
            ms_cnt   <= tick && ms_cnt != 8'hFF ? ms_cnt + 8'h01 : ms_cnt;
        end
    end

    // Next state of the drive sequencer.
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE, ST_HOLD: begin
                if (go) begin
                    next_state = cfg.implied_seek_enable ? ST_SEEK
                               : state == ST_HOLD ? ST_XFER : ST_LOAD;
                end else if (state == ST_HOLD && unload_ok) begin
                    next_state = ST_IDLE;
                end
            end
            ST_SEEK: begin
                if (seek_ok) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (load_ok) begin
                    next_state = ST_XFER;
                end
            end
            ST_XFER: begin
                if (sect_evt && last_sect && !wrap_head) begin
                    next_state = ST_HOLD;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (soft_rst) begin
            next_state = ST_IDLE;
        end
    end

    // Sequencer registers and drive outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            sector_num <= 8'h00;
            head_side  <= 1'b0;
            xfer_done  <= 1'b0;
        end else begin
            state <= next_state;
            if (go) begin
                sector_num <= pwdata[15:8];
                head_side  <= pwdata[24];
                xfer_done  <= 1'b0;
            end else if (state == ST_XFER && sect_evt) begin
                if (last_sect && wrap_head) begin
                    sector_num <= `FDPD_FIRST_SECTOR;
                    head_side  <= 1'b1;
                end else if (last_sect) begin
                    xfer_done  <= 1'b1;
                end else begin
                    sector_num <= sector_num + 8'h01;
                end
            end
        end
    end

    // Head match against each ID field; a new mismatch beats a clear by go.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            id_mismatch <= 1'b0;
        end else begin
            id_mismatch <= (id_evt && id_head != head_side)
                         | (id_mismatch & ~go);
        end
    end

    // Registered mode and drive outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seek_req   <= 1'b0;
            seek_cyl   <= 8'h00;
            head_load  <= 1'b0;
            sector_req <= 1'b0;
            mfm_mode   <= 1'b0;
            fifo_on    <= 1'b0;
            gap2_len   <= `FDPD_GAP2_DEFAULT;
            gap3_len   <= 8'h00;
        end else begin
            seek_req   <= next_state == ST_SEEK;
            seek_cyl   <= cmd.cylinder;
            head_load  <= next_state == ST_LOAD || next_state == ST_XFER
                       || next_state == ST_HOLD;
            sector_req <= next_state == ST_XFER;
            mfm_mode   <= cmd.double_density_select;
            fifo_on    <= ~cfg.fifo_enable_n;
            gap2_len   <= cmd.perp_mode ? perp_gap
                                        : `FDPD_GAP2_DEFAULT;
            gap3_len   <= gap3_length;
        end
    end

    // Checks of the sequencing, FIFO polarity, gap 2 and lock behaviour.
    sequence seq_last_h0;
        state == ST_XFER && sect_evt && last_sect && wrap_head && !soft_rst;
    endsequence
    sequence seq_last_end;
        state == ST_XFER && sect_evt && last_sect && !wrap_head && !soft_rst;
    endsequence

    AST_FIFO_POL: assert property ($changed(cfg.fifo_enable_n)
        |=> fifo_on == !cfg.fifo_enable_n)
        else $error("FIFO enable polarity wrong.");
    AST_SEEK_FIRST: assert property (go && cfg.implied_seek_enable
        && !soft_rst |=> ##1 seek_req)
        else $error("Implied seek not issued.");
    AST_NO_SEEK: assert property (go && !cfg.implied_seek_enable
        |=> ##1 !seek_req)
        else $error("Seek issued with implied seek off.");
    AST_EOT_END: assert property (seq_last_end
        |=> state == ST_HOLD && xfer_done)
        else $error("Transfer did not end at final sector.");
    AST_MT_WRAP: assert property (seq_last_h0
        |=> head_side && sector_num == `FDPD_FIRST_SECTOR
            && state == ST_XFER)
        else $error("Multi-track did not continue on head 1.");
    AST_GAP2: assert property (##1 gap2_len
        == ($past(cmd.perp_mode) ? $past(perp_gap) : `FDPD_GAP2_DEFAULT))
        else $error("Gap 2 length wrong.");
    AST_LOAD_WAIT: assert property (state == ST_LOAD && !load_ok
        |=> !sector_req)
        else $error("Transfer before head load delay.");
    AST_UNLOAD: assert property (state == ST_HOLD && !unload_ok
        && !go && !soft_rst |=> head_load)
        else $error("Head unloaded early.");
    AST_LOCK: assert property (soft_rst && cfg.lock
        |=> $stable(cfg.fifo_enable_n) && $stable(cfg.fifo_threshold)
            && $stable(cfg.precomp_start_track))
        else $error("Locked parameters lost on soft reset.");
    AST_ID_HEAD: assert property (id_evt && id_head != head_side
        |=> id_mismatch)
        else $error("Head mismatch not flagged.");
endmodule

/* fdpd_drive_model.sv */
// Behavioural drive model that answers seeks and streams sector pulses.
`timescale 1ns/1ps
module fdpd_drive_model #(
    parameter int SEEK_DLY = 6
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Requests from the decoder, and a head fault switch from the bench.
    input  wire logic seek_req,
    input  wire logic sector_req,
    input  wire logic head_side,
    input  wire logic bad_head,
    // Drive answers.
    output logic      seek_done_pin,
    output logic      sector_done_pin,
    output logic      id_valid_pin,
    output logic      id_head_pin
);
    int         scnt;
    logic [3:0] ph;

    // The seek ends a while after the request and drops with it.
    always @(posedge clk) begin
        if (!rst_n || !seek_req) begin
            scnt <= 0;
            seek_done_pin <= 1'h0;
        end else if (scnt == SEEK_DLY) begin
            seek_done_pin <= 1'h1;
        end else begin
            scnt <= scnt + 1;
        end
    end

    // One ID field, then one sector end, every 16 cycles of a transfer.
    // Outside its window the head bit is inverted, so a late sample fails.
    always @(posedge clk) begin
        ph <= (!rst_n || !sector_req) ? 4'h0 : ph + 4'h1;
        id_valid_pin <= sector_req && ph >= 4'h2 && ph < 4'h5;
        sector_done_pin <= sector_req && ph >= 4'h9 && ph < 4'hB;
        if (!rst_n) begin
            id_head_pin <= 1'h0;
        end else if (ph == 4'h1) begin
            id_head_pin <= head_side ^ bad_head;
        end else if (ph == 4'h6) begin
            id_head_pin <= ~id_head_pin;
        end
    end
endmodule

/* fdpd_params.svh */
// Offsets, field positions, reset values and timing counts of the decoder.
`ifndef FDPD_PARAMS_SVH
`define FDPD_PARAMS_SVH
`define FDPD_CLK_NS          8
`define FDPD_MS_NS           1000000
`define FDPD_OFF_CFG         8'h00
`define FDPD_OFF_CMD         8'h04
`define FDPD_OFF_GAP         8'h08
`define FDPD_OFF_TIME        8'h0C
`define FDPD_OFF_SRST        8'h10
`define FDPD_OFF_STAT        8'h14
`define FDPD_CMD_GO_BIT      31
`define FDPD_SRST_RATE_BIT   0
`define FDPD_SRST_DOR_BIT    1
`define FDPD_RST_FIFO_N      1'b1
`define FDPD_RST_FIFO_THR    4'h0
`define FDPD_RST_PRECOMP_START_TRACK      8'h00
`define FDPD_GAP2_DEFAULT    8'h16
`define FDPD_FIRST_SECTOR    8'h01
`endif

/* fdpd_pkg.sv */
// Types shared by the command parameter decoder.
package fdpd_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SEEK = 5'h02,
        ST_LOAD = 5'h04,
        ST_XFER = 5'h08,
        ST_HOLD = 5'h10
    } fdpd_state_t;

    // Configure parameters, some of which survive a software reset.
    typedef struct packed {
        logic [7:0] precomp_start_track;
        logic [3:0] fifo_threshold;
        logic       lock;
        logic       implied_seek_enable;
        logic       fifo_enable_n;
    } fdpd_cfg_t;

    // Per-command parameters written in the same word as the go bit.
    typedef struct packed {
        logic       perp_mode;
        logic       double_density_select;
        logic       multi_track_select;
        logic       head_select;
        logic [7:0] final_sector_number;
        logic [7:0] start_sector;
        logic [7:0] cylinder;
    } fdpd_cmd_t;
endpackage

/* tb_top.sv */
// Self-checking bench for the command parameter decoder.
`timescale 1ns/1ps
`include "fdpd_params.svh"
module tb_top;
    localparam int TICK = 4;
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] cmd;
        logic [15:0] gap;
        logic        bad;
        logic [7:0]  e_cnt;
        logic [7:0]  e_sec;
        logic [7:0]  e_gap2;
        logic [4:0]  e_bits;
    } fdpd_row_t;
    // Expected bits: head, density, fifo on, seek seen, id mismatch.
    localparam fdpd_row_t ROWS [4] = '{
        '{32'h1, 32'h8403_0105, 16'h201B, 1'h0, 8'h03, 8'h03, 8'h16, 5'h08},
        '{32'h2, 32'h8904_020A, 16'h352A, 1'h0, 8'h03, 8'h04, 8'h35, 5'h16},
        '{32'h1, 32'h8603_0201, 16'h0010, 1'h0, 8'h05, 8'h03, 8'h16, 5'h18},
        '{32'h1, 32'h8303_0307, 16'h0000, 1'h1, 8'h01, 8'h03, 8'h16, 5'h11}
    };
    logic        clk = 1'h0, rst_n = 1'h0, bad = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, ok, sd_q, sk_q;
    logic        seek_done_pin, sector_done_pin, id_valid_pin, id_head_pin;
    logic        seek_req, head_load, head_side, sector_req, mfm_mode;
    logic        fifo_on, xfer_done;
    logic [7:0]  seek_cyl, sector_num, gap2_len, gap3_len;
    int          fails = 0, check_count = 0, nsec = 0, nseek = 0, n0, s0, n;

    fdpd_decode #(.TICK_CYCLES(TICK)) fdpd_decode_i (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seek_done_pin(seek_done_pin),
        .sector_done_pin(sector_done_pin), .id_valid_pin(id_valid_pin),
        .id_head_pin(id_head_pin), .seek_req(seek_req), .seek_cyl(seek_cyl),
        .head_load(head_load), .head_side(head_side),
        .sector_req(sector_req), .sector_num(sector_num),
        .mfm_mode(mfm_mode), .fifo_on(fifo_on), .gap2_len(gap2_len),
        .gap3_len(gap3_len), .xfer_done(xfer_done));
    fdpd_drive_model fdpd_drive_model_i (.clk(clk), .rst_n(rst_n),
        .seek_req(seek_req), .sector_req(sector_req),
        .head_side(head_side), .bad_head(bad),
        .seek_done_pin(seek_done_pin), .sector_done_pin(sector_done_pin),
        .id_valid_pin(id_valid_pin), .id_head_pin(id_head_pin));

    // The clock runs at 125 MHz.
    always #4 clk = ~clk;

    // Sector ends and seek starts are counted, so each row checks totals.
    always @(posedge clk) begin
        sd_q <= sector_done_pin;
        sk_q <= seek_req;
        if (sector_done_pin === 1'h1 && sd_q === 1'h0) nsec <= nsec + 1;
        if (seek_req === 1'h1 && sk_q === 1'h0) nseek <= nseek + 1;
    end

    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // Only the watchdog ends a transfer that is never answered.
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // An idle edge keeps the next call from re-driving psel at once.
        @(posedge clk);
    endtask

    task automatic wait_done();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (xfer_done !== 1'h1 && n < 900);
        if (n >= 900) fails++;
    endtask

    task automatic stop_test();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence: table of commands, then reset, lock and delays.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h1, `FDPD_OFF_TIME, 32'h0);
        foreach (ROWS[i]) begin
            apb(1'h1, `FDPD_OFF_CFG, ROWS[i].cfg);
            apb(1'h1, `FDPD_OFF_GAP, {16'h0, ROWS[i].gap});
            n0 = nsec;
            s0 = nseek;
            bad <= ROWS[i].bad;
            apb(1'h1, `FDPD_OFF_CMD, ROWS[i].cmd);
            wait_done();
            repeat (4) @(posedge clk);
            chk_pin(8'(nsec - n0), ROWS[i].e_cnt);
            chk_pin(sector_num, ROWS[i].e_sec);
            chk_pin(seek_cyl, ROWS[i].cmd[7:0]);
            chk_pin({7'h0, head_side}, {7'h0, ROWS[i].e_bits[4]});
            chk_pin({7'h0, mfm_mode}, {7'h0, ROWS[i].e_bits[3]});
            chk_pin({7'h0, fifo_on}, {7'h0, ROWS[i].e_bits[2]});
            chk_pin(8'(nseek != s0), {7'h0, ROWS[i].e_bits[1]});
            chk_pin(gap2_len, ROWS[i].e_gap2);
            chk_pin(gap3_len, ROWS[i].gap[7:0]);
            apb(1'h0, `FDPD_OFF_STAT, 32'h0);
            chk_pin({7'h0, rd[17]}, {7'h0, ROWS[i].e_bits[0]});
        end
        bad <= 1'h0;
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk_pin({4'h0, fifo_on, head_load, sector_req, seek_req},
                8'h00);
        apb(1'h0, `FDPD_OFF_CFG, 32'h0);
        chk_bus(rd, 32'h1);
        apb(1'h0, 8'h18, 32'h0);
        chk_bus({rd[30:0], er}, 32'h1);
        // Soft reset without lock restores defaults, with lock keeps them.
        apb(1'h1, `FDPD_OFF_CFG, 32'h0000_A5F0);
        apb(1'h1, `FDPD_OFF_SRST, 32'h1);
        apb(1'h0, `FDPD_OFF_CFG, 32'h0);
        chk_bus(rd, 32'h0000_0001);
        apb(1'h1, `FDPD_OFF_CFG, 32'h0000_A5F4);
        apb(1'h1, `FDPD_OFF_SRST, 32'h2);
        apb(1'h0, `FDPD_OFF_CFG, 32'h0);
        chk_bus(rd, 32'h0000_A5F4);
        chk_pin({7'h0, fifo_on}, 8'h01);
        // Load delay of two ticks, unload delay of one tick.
        apb(1'h1, `FDPD_OFF_CFG, 32'h1);
        apb(1'h1, `FDPD_OFF_TIME, 32'h0000_0102);
        apb(1'h1, `FDPD_OFF_CMD, 32'h8401_0100);
        for (n = 0; head_load !== 1'h1 && n < 50; n++) @(posedge clk);
        for (n = 0; sector_req !== 1'h1 && n < 99; n++) @(posedge clk);
        ok = n >= 2 * TICK && n <= 2 * TICK + 2;
        chk_pin({7'h0, ok}, 8'h01);
        wait_done();
        for (n = 0; head_load === 1'h1 && n < 99; n++) @(posedge clk);
        ok = n >= TICK && n <= TICK + 3;
        chk_pin({7'h0, ok}, 8'h01);
        stop_test();
    end

    // Watchdog: the whole sequence needs a few hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
